// ---- logic/acr_pkg.sv ----
// Package for the converter result and channel register block.
// Assumes an 8-bit register port on one peripheral clock.
package acr_pkg;

  // Register offsets (byte addresses on the 8-bit register port)
  localparam logic [5:0] OFF_CTRLA     = 6'h00;
  localparam logic [5:0] OFF_CTRLB     = 6'h01;
  localparam logic [5:0] OFF_LATCH     = 6'h07;
  localparam logic [5:0] OFF_TRIM_LO   = 6'h0c;
  localparam logic [5:0] OFF_TRIM_HI   = 6'h0d;
  localparam logic [5:0] OFF_RES_LO    = 6'h10;
  localparam logic [5:0] OFF_RES_HI    = 6'h11;
  localparam logic [5:0] OFF_THR_LO    = 6'h18;
  localparam logic [5:0] OFF_THR_HI    = 6'h19;
  localparam logic [5:0] OFF_CH_CTRL   = 6'h20;
  localparam logic [5:0] OFF_ROUTE     = 6'h21;

  // Field positions
  localparam int GLOBAL_GO_BIT   = 2;
  localparam int SIGNED_BIT      = 4;
  localparam int FMT_LSB         = 1;
  localparam int CH_GO_BIT       = 7;
  localparam int GAIN_LSB        = 2;
  localparam int KIND_LSB        = 0;
  localparam int POS_LSB         = 3;
  localparam int NEG_LSB         = 0;

  // Read-data masks of implemented bits
  localparam logic [7:0] MASK_CTRLB   = 8'h1e;
  localparam logic [7:0] MASK_TRIM_HI = 8'h0f;
  localparam logic [7:0] MASK_CH_CTRL = 8'h1f;
  localparam logic [7:0] MASK_ROUTE   = 8'h7f;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    ACR_FMT_R12 = 2'b00,
    ACR_FMT_RSV = 2'b01,
    ACR_FMT_R8  = 2'b10,
    ACR_FMT_L12 = 2'b11
  } acr_fmt_t;

  typedef enum logic [1:0] {
    ACR_KIND_ONCHIP = 2'b00,
    ACR_KIND_ONE    = 2'b01,
    ACR_KIND_TWO    = 2'b10,
    ACR_KIND_TWO_G  = 2'b11
  } acr_kind_t;

  // Positive source decoded for the analog side
  localparam logic [3:0] POS_TEMP   = 4'h0;
  localparam logic [3:0] POS_BGAP   = 4'h1;
  localparam logic [3:0] POS_TENTH  = 4'h2;

  // Negative source classes
  typedef enum logic [1:0] {
    ACR_NEG_NONE = 2'b00,
    ACR_NEG_PIN  = 2'b01,
    ACR_NEG_PAD  = 2'b10,
    ACR_NEG_INT  = 2'b11
  } acr_neg_t;

  typedef struct packed {
    logic       onchip;
    logic [3:0] pos_sel;
    acr_neg_t   neg_kind;
    logic [2:0] neg_pin;
    logic       pos_ok;
    logic [2:0] gain;
    logic       is_signed;
  } acr_route_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acr_bus_t;

endpackage : acr_pkg

// ---- logic/acr_regs.sv ----
// Converter result, trim, threshold and channel control registers.
// Assumes an 8-bit register port and a converter core on the same clock.
//
// Summary of operation
// - Reading a 16-bit pair's low byte copies its high byte into latch.
// - The byte latch is an ordinary read/write eight-bit register.
// - Twelve-bit trim word: low byte bits 7:0, high byte bits 3:0.
// - Left-adjusted: high byte result 11:4, low byte 7:4 result 3:0.
// - Right-adjusted: high nibble sign-extends in differential, else zero.
// - Eight-bit: high byte replicates bit 7 when signed, else zero.
// - Right-adjusted and 8-bit: low byte holds eight lowest result bits.
// - Result bytes form one 16-bit word read through the byte latch.
// - Sixteen-bit compare threshold, two's complement when signed.
// - Writing one to start bit starts conversion; hardware clears it.
// - Writing start while already set has no extra effect unless conv_began is high; then start stays set.
// - Channel start bit aliases the global channel start bit.
// - Gain code 000..110 gives 1x..64x, 111 gives one half.
// - Changing source kind may corrupt in-flight conversions.
// - Unsigned: kind 00 on-chip, 01 single pin, 10/11 reserved.
// - Signed: adds 10 differential, 11 differential with gain.
// - On-chip positive select: temperature, bandgap, tenth supply; rest reserved.
// - Pin kinds: positive select n routes analog pin n.
// - Negative select used only for differential measurements.
// - Differential: 000-011 pins 0-3, 101 pad ground, 111 internal.
// - With gain: 000-011 pins 4-7, 100 internal, 111 pad ground.
// - Signedness select resets to zero, unsigned; one selects signed.
// - Format: 00 right 12-bit, 10 8-bit, 11 left 12-bit.
`timescale 1ns/1ps
module acr_regs #(
  parameter int RES_W = 12
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire acr_pkg::acr_bus_t   bus,
  output logic [7:0]               rdata,
  // Converter core
  input  wire logic                conv_began,
  input  wire logic                conv_done,
  input  wire logic [RES_W-1:0]    conv_result,
  output logic                     conv_start,
  output logic [RES_W-1:0]         trim_word,
  output logic [15:0]              compare_threshold,
  output acr_pkg::acr_fmt_t        result_format,
  output acr_pkg::acr_route_t      route
);

  // Layout logic below is written for a 12-bit result only
  if (RES_W != 12) begin : g_res_w_check
    $error("acr_regs supports a 12-bit result only");
  end

  logic [7:0]  byte_latch;
  logic [7:0]  trim_low_byte;
  logic [3:0]  trim_high;
  logic [7:0]  threshold_low_byte;
  logic [7:0]  threshold_high_byte;
  logic        global_channel_go;
  logic        signedness_select;
  logic [1:0]  fmt;
  logic [2:0]  gain;
  logic [1:0]  channel_source_kind;
  logic [3:0]  positive_input_select;
  logic [2:0]  negative_input_select;
  logic [11:0] conversion_result;
  logic [15:0] channel_result_word;
  logic        wr_go;
  logic        two_input_measure;
  logic        two_input_amplified;

  function automatic logic hit(input acr_pkg::acr_bus_t b, input logic [5:0] off);
    hit = b.addr == off;
  endfunction : hit

  assign two_input_measure   = signedness_select && channel_source_kind == acr_pkg::ACR_KIND_TWO;
  assign two_input_amplified = signedness_select && channel_source_kind == acr_pkg::ACR_KIND_TWO_G;

  // Byte latch: software access or high-byte snapshot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_latch <= acr_pkg::RST_BYTE;
    end else if (bus.wr && hit(bus, acr_pkg::OFF_LATCH)) begin
      byte_latch <= bus.wdata;
    end else if (bus.rd && hit(bus, acr_pkg::OFF_RES_LO)) begin
      byte_latch <= channel_result_word[15:8];
    end else if (bus.rd && hit(bus, acr_pkg::OFF_THR_LO)) begin
      byte_latch <= threshold_high_byte;
    end else if (bus.rd && hit(bus, acr_pkg::OFF_TRIM_LO)) begin
      byte_latch <= {4'h0, trim_high};
    end
  end

  // Trim word, loaded only by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_low_byte <= acr_pkg::RST_BYTE;
      trim_high     <= 4'h0;
    end else if (bus.wr) begin
      if (hit(bus, acr_pkg::OFF_TRIM_LO)) trim_low_byte <= bus.wdata;
      if (hit(bus, acr_pkg::OFF_TRIM_HI)) trim_high <= bus.wdata[3:0];
    end
  end
  assign trim_word = {trim_high, trim_low_byte};

  // Compare threshold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_low_byte  <= acr_pkg::RST_BYTE;
      threshold_high_byte <= acr_pkg::RST_BYTE;
    end else if (bus.wr) begin
      if (hit(bus, acr_pkg::OFF_THR_LO)) threshold_low_byte <= bus.wdata;
      if (hit(bus, acr_pkg::OFF_THR_HI)) threshold_high_byte <= bus.wdata;
    end
  end
  assign compare_threshold = {threshold_high_byte, threshold_low_byte};

  // Global signedness and format
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      signedness_select <= 1'b0;
      fmt               <= 2'b00;
    end else if (bus.wr && hit(bus, acr_pkg::OFF_CTRLB)) begin
      signedness_select <= bus.wdata[acr_pkg::SIGNED_BIT];
      fmt               <= bus.wdata[acr_pkg::FMT_LSB +: 2];
    end
  end
  assign result_format = acr_pkg::acr_fmt_t'(fmt);

  // Start bit shared by both control registers
  assign wr_go = bus.wr && ((hit(bus, acr_pkg::OFF_CH_CTRL) && bus.wdata[acr_pkg::CH_GO_BIT])
               || (hit(bus, acr_pkg::OFF_CTRLA) && bus.wdata[acr_pkg::GLOBAL_GO_BIT]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_channel_go <= 1'b0;
    end else if (wr_go) begin
      global_channel_go <= 1'b1;
    end else if (conv_began) begin
      global_channel_go <= 1'b0;
    end
  end
  assign conv_start = global_channel_go;

  // Channel control and input route
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain                  <= 3'h0;
      channel_source_kind   <= 2'h0;
      positive_input_select <= 4'h0;
      negative_input_select <= 3'h0;
    end else if (bus.wr) begin
      if (hit(bus, acr_pkg::OFF_CH_CTRL)) begin
        gain                <= bus.wdata[acr_pkg::GAIN_LSB +: 3];
        channel_source_kind <= bus.wdata[acr_pkg::KIND_LSB +: 2];
      end
      if (hit(bus, acr_pkg::OFF_ROUTE)) begin
        positive_input_select <= bus.wdata[acr_pkg::POS_LSB +: 4];
        negative_input_select <= bus.wdata[acr_pkg::NEG_LSB +: 3];
      end
    end
  end

  // Routing decode for the analog multiplexer
  always_comb begin
    route           = '0;
    route.gain      = gain;
    route.is_signed = signedness_select;
    route.pos_sel   = positive_input_select;
    route.neg_kind  = acr_pkg::ACR_NEG_NONE;
    unique case (acr_pkg::acr_kind_t'(channel_source_kind))
      acr_pkg::ACR_KIND_ONCHIP: begin
        route.onchip = 1'b1;
        route.pos_ok = positive_input_select <= acr_pkg::POS_TENTH;
      end
      acr_pkg::ACR_KIND_ONE: begin
        route.pos_ok = 1'b1;
      end
      acr_pkg::ACR_KIND_TWO: begin
        route.pos_ok = signedness_select;
        if (!negative_input_select[2]) begin
          route.neg_kind = acr_pkg::ACR_NEG_PIN;
          route.neg_pin  = negative_input_select;
        end else if (negative_input_select == 3'h5) begin
          route.neg_kind = acr_pkg::ACR_NEG_PAD;
        end else if (negative_input_select == 3'h7) begin
          route.neg_kind = acr_pkg::ACR_NEG_INT;
        end else begin
          route.pos_ok = 1'b0;
        end
      end
      acr_pkg::ACR_KIND_TWO_G: begin
        route.pos_ok = signedness_select;
        if (!negative_input_select[2]) begin
          route.neg_kind = acr_pkg::ACR_NEG_PIN;
          route.neg_pin  = {1'b1, negative_input_select[1:0]};
        end else if (negative_input_select == 3'h4) begin
          route.neg_kind = acr_pkg::ACR_NEG_INT;
        end else if (negative_input_select == 3'h7) begin
          route.neg_kind = acr_pkg::ACR_NEG_PAD;
        end else begin
          route.pos_ok = 1'b0;
        end
      end
    endcase
  end

  // Result capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result <= 12'h000;
    end else if (conv_done) begin
      conversion_result <= conv_result;
    end
  end

  // Result layout by format
  always_comb begin
    channel_result_word = 16'h0000;
    unique case (acr_pkg::acr_fmt_t'(fmt))
      acr_pkg::ACR_FMT_L12: begin
        channel_result_word = {conversion_result, 4'h0};
      end
      acr_pkg::ACR_FMT_R8: begin
        channel_result_word = {{8{signedness_select & conversion_result[7]}},
                               conversion_result[7:0]};
      end
      default: begin
        channel_result_word = {{4{(two_input_measure | two_input_amplified) & conversion_result[11]}},
                               conversion_result};
      end
    endcase
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        acr_pkg::OFF_CTRLA:   rdata <= {5'h00, global_channel_go, 2'b00};
        acr_pkg::OFF_CTRLB:   rdata <= {3'h0, signedness_select, 1'b0, fmt, 1'b0} & acr_pkg::MASK_CTRLB;
        acr_pkg::OFF_LATCH:   rdata <= byte_latch;
        acr_pkg::OFF_TRIM_LO: rdata <= trim_low_byte;
        acr_pkg::OFF_TRIM_HI: rdata <= {4'h0, trim_high} & acr_pkg::MASK_TRIM_HI;
        acr_pkg::OFF_RES_LO:  rdata <= channel_result_word[7:0];
        acr_pkg::OFF_RES_HI:  rdata <= byte_latch;
        acr_pkg::OFF_THR_LO:  rdata <= threshold_low_byte;
        acr_pkg::OFF_THR_HI:  rdata <= byte_latch;
        acr_pkg::OFF_CH_CTRL: rdata <= {global_channel_go, 2'b00, gain, channel_source_kind};
        acr_pkg::OFF_ROUTE:   rdata <= {1'b0, positive_input_select, negative_input_select} & acr_pkg::MASK_ROUTE;
        default:              rdata <= 8'h00;
      endcase
    end
  end

endmodule : acr_regs

// ---- sim/acr_regs_monitor.sv ----
// Port checker for the result and channel register block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module acr_regs_monitor #(
  parameter int RES_W = 12
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Register port
  input wire acr_pkg::acr_bus_t   bus,
  input wire logic [7:0]          rdata,
  // Converter core
  input wire logic                conv_began,
  input wire logic                conv_done,
  input wire logic [RES_W-1:0]    conv_result,
  input wire logic                conv_start,
  input wire logic [RES_W-1:0]    trim_word,
  input wire logic [15:0]         compare_threshold,
  input wire acr_pkg::acr_fmt_t   result_format,
  input wire acr_pkg::acr_route_t route
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  start_set_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_CH_CTRL && bus.wdata[7] |=> conv_start)
    else $error("start not set");
  start_alias_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_CTRLA && bus.wdata[2] |=> conv_start)
    else $error("alias start not set");
  start_clear_a: assert property (conv_start && conv_began && !bus.wr |=> !conv_start)
    else $error("start not cleared");
  start_hold_a: assert property (conv_start && !conv_began && !bus.wr |=> conv_start)
    else $error("start dropped early");
  trim_low_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_TRIM_LO |=> trim_word[7:0] == $past(bus.wdata))
    else $error("trim low wrong");
  trim_high_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_TRIM_HI
    |=> trim_word[11:8] == $past(bus.wdata[3:0]))
    else $error("trim high wrong");
  thr_high_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_THR_HI
    |=> compare_threshold[15:8] == $past(bus.wdata))
    else $error("threshold high wrong");
  fmt_write_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_CTRLB |=> result_format == $past(bus.wdata[2:1]))
    else $error("format wrong");
  gain_write_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_CH_CTRL |=> route.gain == $past(bus.wdata[4:2]))
    else $error("gain wrong");
  unmapped_zero_a: assert property (bus.rd && bus.addr == 6'h3f |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  start_cause_a: assert property ($rose(conv_start) |-> $past(bus.wr))
    else $error("start rose without a write");
  thr_low_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_THR_LO
    |=> compare_threshold[7:0] == $past(bus.wdata))
    else $error("threshold low wrong");
  signed_write_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_CTRLB
    |=> route.is_signed == $past(bus.wdata[4]))
    else $error("signedness wrong");
  pos_write_a: assert property (bus.wr && bus.addr == acr_pkg::OFF_ROUTE |=> route.pos_sel == $past(bus.wdata[6:3]))
    else $error("positive select wrong");
endmodule : acr_regs_monitor

bind acr_regs acr_regs_monitor #(.RES_W(RES_W)) u_mon (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .conv_began(conv_began), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
  .trim_word(trim_word), .compare_threshold(compare_threshold), .result_format(result_format), .route(route));

// ---- sim/acr_core_model.sv ----
// Behavioural converter core facing the register block.
// Assumes the block clock; one conversion at a time.
`timescale 1ns/1ps
module acr_core_model (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Block side
  input wire logic        conv_start,
  input wire logic [11:0] sample,
  output logic            conv_began,
  output logic            conv_done,
  output logic [11:0]     conv_result
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= 4'h0;
      conv_began  <= 1'b0;
      conv_done   <= 1'b0;
      conv_result <= 12'h000;
    end else begin
      if (cnt != 4'h0) cnt <= (cnt == 4'hc) ? 4'h0 : cnt + 4'h1;
      else if (conv_start) cnt <= 4'h1;
      conv_began  <= (cnt == 4'h6);
      conv_done   <= (cnt == 4'hc);
      // Result only valid with done
      conv_result <= (cnt == 4'hc) ? sample : ~conv_result;
    end
  end
endmodule : acr_core_model

// ---- sim/test_adc_result_and_channel_regs.sv ----
// Self-checking bench for the result and channel register block.
// Assumes the core model in acr_core_model.sv.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("wrong value %0t %s", $time, m); end end
module test_adc_result_and_channel_regs;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  acr_pkg::acr_bus_t   bus = '0;
  logic [11:0]         sample = 12'h000;
  logic [7:0]          rdata;
  logic                conv_began, conv_done, conv_start;
  logic [11:0]         conv_result, trim_word;
  logic [15:0]         compare_threshold;
  acr_pkg::acr_fmt_t   result_format;
  acr_pkg::acr_route_t route;
  int                  error_cnt = 0;
  int                  n_tests = 0;
  int                  began_cnt = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (conv_began === 1'b1) began_cnt++;
  acr_regs DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .conv_began(conv_began), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .trim_word(trim_word), .compare_threshold(compare_threshold),
    .result_format(result_format), .route(route));
  acr_core_model core (.clk(clk), .rst_n(rst_n), .conv_start(conv_start), .sample(sample), .conv_began(conv_began),
    .conv_done(conv_done), .conv_result(conv_result));
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic chkr(input logic [5:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, e, m)
  endtask : chkr
  task automatic wait_done;
    int i;
    i = 0;
    while (conv_done !== 1'b1 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK(i < 60, 1'b1, "no done")
  endtask : wait_done
  task automatic t_regs;
    `CHK(route.is_signed, 1'b0, "signed reset")
    chkr(acr_pkg::OFF_CTRLB, 8'h00, "ctrlb reset");
    wr(acr_pkg::OFF_LATCH, 8'h5a);
    chkr(acr_pkg::OFF_LATCH, 8'h5a, "latch rw");
    wr(acr_pkg::OFF_TRIM_LO, 8'h3c);
    wr(acr_pkg::OFF_TRIM_HI, 8'hff);
    `CHK(trim_word, 12'hf3c, "trim word")
    chkr(acr_pkg::OFF_TRIM_LO, 8'h3c, "trim low");
    chkr(acr_pkg::OFF_TRIM_HI, 8'h0f, "trim high");
    wr(acr_pkg::OFF_THR_LO, 8'h34);
    wr(acr_pkg::OFF_THR_HI, 8'h92);
    `CHK(compare_threshold, 16'h9234, "threshold")
    chkr(acr_pkg::OFF_THR_LO, 8'h34, "thr low");
    chkr(acr_pkg::OFF_THR_HI, 8'h92, "thr high");
    wr(6'h3f, 8'hff);
    chkr(6'h3f, 8'h00, "unmapped");
    wr(acr_pkg::OFF_ROUTE, 8'hff);
    chkr(acr_pkg::OFF_ROUTE, 8'h7f, "route rsv");
    wr(acr_pkg::OFF_CH_CTRL, 8'h7f);
    chkr(acr_pkg::OFF_CH_CTRL, 8'h1f, "ctrl rsv");
  endtask : t_regs
  task automatic t_start;
    began_cnt = 0;
    wr(acr_pkg::OFF_CH_CTRL, 8'h81);
    `CHK(conv_start, 1'b1, "start not pending")
    wr(acr_pkg::OFF_CH_CTRL, 8'h81);
    chkr(acr_pkg::OFF_CTRLA, 8'h04, "alias read");
    wait_done();
    repeat (20) @(posedge clk);
    `CHK(began_cnt, 1, "second start")
    `CHK(conv_start, 1'b0, "start still pending")
    chkr(acr_pkg::OFF_CH_CTRL, 8'h01, "start clear");
    wr(acr_pkg::OFF_CTRLA, 8'h04);
    chkr(acr_pkg::OFF_CH_CTRL, 8'h81, "alias write");
    wait_done();
  endtask : t_start
  task automatic t_result;
    // ctrlb, channel control, sample, high, low
    logic [43:0] tab [6] = '{{8'h00, 8'h81, 12'hab5, 8'h0a, 8'hb5}, {8'h10, 8'h82, 12'hab5, 8'hfa, 8'hb5},
      {8'h10, 8'h81, 12'h9c3, 8'h09, 8'hc3}, {8'h06, 8'h81, 12'hab5, 8'hab, 8'h50},
      {8'h14, 8'h82, 12'h0c3, 8'hff, 8'hc3}, {8'h04, 8'h81, 12'h0c3, 8'h00, 8'hc3}};
    foreach (tab[i]) begin
      @(posedge clk);
      sample <= tab[i][27:16];
      wr(acr_pkg::OFF_CTRLB, tab[i][43:36]);
      `CHK(result_format, acr_pkg::acr_fmt_t'(tab[i][38:37]), "format")
      wr(acr_pkg::OFF_CH_CTRL, tab[i][35:28]);
      wait_done();
      chkr(acr_pkg::OFF_RES_LO, tab[i][7:0], "result low");
      chkr(acr_pkg::OFF_LATCH, tab[i][15:8], "latch load");
      chkr(acr_pkg::OFF_RES_HI, tab[i][15:8], "result high");
    end
  endtask : t_result
  task automatic t_route;
    // channel control, route, onchip, pos_ok, negative kind, negative pin
    logic [23:0] tab [11] = '{{8'h00, 8'h10, 4'hc, 4'h0}, {8'h00, 8'h18, 4'h8, 4'h0}, {8'h01, 8'h7d, 4'h4, 4'h0},
      {8'h02, 8'h25, 4'h6, 4'h0}, {8'h02, 8'h27, 4'h7, 4'h0}, {8'h02, 8'h22, 4'h5, 4'h2}, {8'h03, 8'h24, 4'h7, 4'h0},
      {8'h03, 8'h27, 4'h6, 4'h0}, {8'h03, 8'h6a, 4'h5, 4'h6}, {8'h02, 8'h0c, 4'h0, 4'h0}, {8'h03, 8'h0d, 4'h0, 4'h0}};
    wr(acr_pkg::OFF_CTRLB, 8'h10);
    foreach (tab[i]) begin
      wr(acr_pkg::OFF_CH_CTRL, tab[i][23:16] | {3'h0, 3'(i), 2'h0});
      wr(acr_pkg::OFF_ROUTE, tab[i][15:8]);
      `CHK(route.gain, 3'(i), "gain")
      `CHK(route.is_signed, 1'b1, "signed")
      `CHK(route.onchip, tab[i][7], "onchip")
      `CHK(route.pos_ok, tab[i][6], "pos ok")
      `CHK(route.pos_sel, tab[i][14:11], "pos select")
      `CHK(route.neg_kind, acr_pkg::acr_neg_t'(tab[i][5:4]), "neg kind")
      if (tab[i][5:4] == 2'b01) `CHK(route.neg_pin, tab[i][2:0], "neg pin")
    end
    wr(acr_pkg::OFF_CTRLB, 8'h00);
    wr(acr_pkg::OFF_CH_CTRL, 8'h02);
    `CHK(route.is_signed, 1'b0, "unsigned")
    `CHK(route.pos_ok, 1'b0, "unsigned kind reserved")
  endtask : t_route
  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_start();
    t_result();
    t_route();
    stop_test();
  end
endmodule : test_adc_result_and_channel_regs
